// File: rtl/fst_cfg.svh
// Constants of the fail-safe timer: register indices, field positions,
// reset values, codes and timing counts.
// Assumes a 125 MHz clock that also serves as the high-frequency clock.
`ifndef FST_CFG_SVH
`define FST_CFG_SVH

`define FST_CONFIG_IDX   8'h34
`define FST_CODE_IDX     8'h35
`define FST_STATUS_IDX   8'h3C

`define FST_EN_BIT       3
`define FST_DTS_MSB      2
`define FST_DTS_LSB      1
`define FST_OUT_BIT      0

`define FST_EN_RST       1'b1
`define FST_DTS_RST      2'h0
`define FST_OUT_RST      1'b1

`define FST_CODE_CLEAR   8'h4E
`define FST_CODE_DISABLE 8'hB1

`define FST_DIV_W        25
`define FST_TAP_BASE     23

`define FST_RST_TIME_FC  16
`define FST_CLK_KHZ      125000
`define FST_FC_KHZ       125000
`define FST_RST_CYC      \
   ((`FST_RST_TIME_FC * `FST_CLK_KHZ + `FST_FC_KHZ - 1) / `FST_FC_KHZ)

`endif

// File: rtl/fst_pkg.sv
// Types and shared decode of the fail-safe timer.
// Assumes fst_cfg.svh is on the include path.
package fst_pkg;

   typedef enum logic [1:0] {
      FST_IDLE  = 2'b01,
      FST_PULSE = 2'b10
   } fst_rst_state_t;

   // Mask of divider bits that must all be set for one counter step
   function automatic logic [31:0] fst_tap_mask(input logic [4:0] base,
                                                input logic [1:0] dts,
                                                input logic       dv);
      logic [4:0] k;
      k = base - {2'b00, dts, 1'b0} + {4'h0, dv};
      return (32'h00000001 << k) - 32'h00000001;
   endfunction

endpackage

// File: rtl/fst_divider.sv
// Free-running clock divider of the fail-safe timer.
// Assumes the parent holds run_i low in the low-power modes.
`timescale 1ns/1ns
`include "fst_cfg.svh"
module fst_divider #(
   parameter int DIV_W    = `FST_DIV_W,
   parameter int TAP_BASE = `FST_TAP_BASE
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [1:0] dts_i,
   input  wire logic       dv_i,
   output logic            tick_o
);
   import fst_pkg::*;

   logic [DIV_W-1:0] div;
   logic [31:0]      mask;

   // One tick every quarter of the detection time
   always_comb begin
      mask   = fst_tap_mask(5'(TAP_BASE), dts_i, dv_i);
      tick_o = run_i && ((div & mask[DIV_W-1:0]) == mask[DIV_W-1:0]);
   end

   // Only a reset clears the divider, so a clear code leaves it running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div <= '0;
      end else if (run_i) begin
         div <= div + 1'b1;
      end
   end

endmodule

// File: rtl/fst_watchdog.sv
// Fail-safe timer top: Wishbone slave, two-stage counter, reset pulse
// and pseudo NMI request.
// Assumes classic Wishbone, one clock, and that the CPU reports the end
// of its non-maskable handler and any software interrupt in service.
`timescale 1ns/1ns
`include "fst_cfg.svh"
module fst_watchdog #(
   parameter int DIV_W    = `FST_DIV_W,
   parameter int TAP_BASE = `FST_TAP_BASE
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        stop_i,
   input  wire logic        idle_i,
   input  wire logic        divider_stage_sel_i,
   input  wire logic        nmi_return_from_nmi_instr_done_i,
   input  wire logic        sw_nmi_busy_i,
   output logic             wd_pseudo_nmi_o,
   output logic             chip_reset_o,
   output logic             reset_pin_o,
   output logic             reset_pin_oe_o
);
   import fst_pkg::*;

   localparam int RST_CYC = `FST_RST_CYC;

   logic           wb_hit;
   logic           wb_done;
   logic [7:0]     wb_idx;
   logic           wr_cfg;
   logic           wr_code;
   logic [7:0]     wdat;
   logic           code_clear;
   logic           code_disable;

   logic           wd_run_enable;
   logic [1:0]     detect_time_sel;
   logic           overflow_action_sel;
   logic           disabled;
   logic [1:0]     bin_cnt;
   logic           tick;
   logic           run;
   logic           ovf;

   logic           nmi_pending;
   logic           nmi_busy;
   logic           nmi_issue;

   fst_rst_state_t rst_state;
   logic [4:0]     rst_len;
   logic           pulse_active;
   logic           int_rst;

   function automatic logic reg_hit(input logic [7:0] idx,
                                    input logic [7:0] want);
      return idx == want;
   endfunction

   // Bus decode; registers sit in byte lane 0, except status bit 8 (nmi_busy)
   always_comb begin
      wb_hit       = wb_cyc_i && wb_stb_i && !wb_ack_o;
      // Writes land on the edge that ends the cycle with ack high
      wb_done      = wb_cyc_i && wb_stb_i && wb_ack_o;
      wb_idx       = wb_adr_i[9:2];
      wdat         = wb_dat_i[7:0];
      wr_cfg       = wb_done && wb_we_i && wb_sel_i[0]
                     && reg_hit(wb_idx, `FST_CONFIG_IDX);
      wr_code      = wb_done && wb_we_i && wb_sel_i[0]
                     && reg_hit(wb_idx, `FST_CODE_IDX);
      code_clear   = wr_code && (wdat == `FST_CODE_CLEAR);
      code_disable = wr_code && (wdat == `FST_CODE_DISABLE);
   end

   // The watchdog's own pulse resets the block like the reset input, except the bus answer and the reset pulse logic
   always_comb begin
      pulse_active = (rst_state == FST_PULSE);
      int_rst      = rst_i || pulse_active;
   end

   // Config register
   always_ff @(posedge clk_i) begin
      if (int_rst) begin
         wd_run_enable       <= `FST_EN_RST;
         detect_time_sel     <= `FST_DTS_RST;
         overflow_action_sel <= `FST_OUT_RST;
      end else if (wr_cfg) begin
         wd_run_enable       <= wdat[`FST_EN_BIT];
         detect_time_sel     <= wdat[`FST_DTS_MSB:`FST_DTS_LSB];
         // AND keeps interrupt mode once chosen
         overflow_action_sel <= overflow_action_sel
                                & wdat[`FST_OUT_BIT];
      end
   end

   // Disable takes the enable bit as it stands at the code write
   always_ff @(posedge clk_i) begin
      if (int_rst) begin
         disabled <= 1'b0;
      end else if (code_disable && !wd_run_enable) begin
         disabled <= 1'b1;
      end else if (wr_cfg && wdat[`FST_EN_BIT]) begin
         disabled <= 1'b0;
      end
   end

   always_comb begin
      run = !disabled && !stop_i && !idle_i;
      // Three or four ticks after a clear, since the divider keeps phase
      ovf = tick && run && (bin_cnt == 2'h3) && !code_clear;
   end

   fst_divider #(
      .DIV_W    (DIV_W),
      .TAP_BASE (TAP_BASE)
   ) u_div (
      .clk_i  (clk_i),
      .rst_i  (int_rst),
      .run_i  (!stop_i && !idle_i),
      .dts_i  (detect_time_sel),
      .dv_i   (divider_stage_sel_i),
      .tick_o (tick)
   );

   // Two-stage binary counter
   always_ff @(posedge clk_i) begin
      if (int_rst) begin
         bin_cnt <= 2'h0;
      end else if (disabled) begin
         bin_cnt <= 2'h0;
      end else if (code_clear) begin
         bin_cnt <= 2'h0;
      end else if (tick && run) begin
         bin_cnt <= bin_cnt + 2'h1;
      end
   end

   // Interrupt path: a new request waits while a handler is in service
   always_comb begin
      nmi_issue = nmi_pending && !nmi_busy && !sw_nmi_busy_i;
   end

   always_ff @(posedge clk_i) begin
      if (int_rst) begin
         nmi_pending <= 1'b0;
      end else if (ovf && !overflow_action_sel) begin
         nmi_pending <= 1'b1;
      end else if (nmi_issue) begin
         nmi_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (int_rst) begin
         nmi_busy <= 1'b0;
      end else if (nmi_issue) begin
         nmi_busy <= 1'b1;
      end else if (nmi_return_from_nmi_instr_done_i) begin
         nmi_busy <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (int_rst) begin
         wd_pseudo_nmi_o <= 1'b0;
      end else begin
         wd_pseudo_nmi_o <= nmi_issue;
      end
   end

   // Reset pulse; if the pin feeds rst_i back it is cut short
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rst_state      <= FST_IDLE;
         rst_len        <= 5'h00;
         reset_pin_oe_o <= 1'b0;
         chip_reset_o   <= 1'b0;
      end else begin
         case (rst_state)
            FST_IDLE: begin
               if (ovf && overflow_action_sel) begin
                  rst_state      <= FST_PULSE;
                  rst_len        <= 5'h00;
                  reset_pin_oe_o <= 1'b1;
                  chip_reset_o   <= 1'b1;
               end
            end
            FST_PULSE: begin
               rst_len <= rst_len + 5'h01;
               if (rst_len == 5'(RST_CYC - 1)) begin
                  rst_state      <= FST_IDLE;
                  reset_pin_oe_o <= 1'b0;
                  chip_reset_o   <= 1'b0;
               end
            end
            default: begin
               rst_state      <= FST_IDLE;
               rst_len        <= 5'h00;
               reset_pin_oe_o <= 1'b0;
               chip_reset_o   <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain pin only ever drives low
   always_ff @(posedge clk_i) begin
      reset_pin_o <= 1'b0;
   end

   // Bus answer one cycle after the request, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= 32'h00000000;
         if (wb_hit && !wb_we_i && reg_hit(wb_idx, `FST_STATUS_IDX)) begin
            wb_dat_o <= {23'h000000, nmi_busy, nmi_pending, disabled,
                         overflow_action_sel, detect_time_sel,
                         wd_run_enable, bin_cnt};
         end
      end
   end

   // Ticks since the last clear; an independent shadow for the checks
   logic [1:0]     clr_ticks;

   always_ff @(posedge clk_i) begin
      if (int_rst || code_clear || disabled) begin
         clr_ticks <= 2'h0;
      end else if (tick && run && (clr_ticks != 2'h3)) begin
         clr_ticks <= clr_ticks + 2'h1;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_ovf_reset;
      ovf && overflow_action_sel && (rst_state == FST_IDLE);
   endsequence

   sequence s_pin_low_16;
      reset_pin_oe_o [*8] ##1 reset_pin_oe_o [*8];
   endsequence

   sequence s_other_code;
      wr_code && !code_clear && !code_disable && !int_rst && !tick;
   endsequence

   property p_pulse_len;
      $rose(reset_pin_oe_o) |-> s_pin_low_16 ##1 !reset_pin_oe_o;
   endproperty

   out_sel_lock_a: assert property (
      !overflow_action_sel && !int_rst |=> !overflow_action_sel)
      else $error("output select returned to reset");

   enable_after_reset_a: assert property (
      $past(rst_i) |-> wd_run_enable && overflow_action_sel)
      else $error("enable not set after reset");

   clear_counter_a: assert property (
      code_clear && !int_rst |=> bin_cnt == 2'h0)
      else $error("clear code did not zero counter");

   ovf_reset_a: assert property (
      s_ovf_reset |=> reset_pin_oe_o && chip_reset_o)
      else $error("overflow gave no reset pulse");

   ovf_nmi_a: assert property (
      ovf && !overflow_action_sel && !int_rst |=> nmi_pending)
      else $error("overflow gave no interrupt request");

   pause_hold_a: assert property (
      (stop_i || idle_i) && !int_rst && !wr_code |=> $stable(bin_cnt))
      else $error("counter moved while paused");

   cfg_read_zero_a: assert property (
      wb_hit && !wb_we_i && reg_hit(wb_idx, `FST_CONFIG_IDX)
      |=> wb_ack_o && (wb_dat_o == 32'h00000000))
      else $error("config register read back");

   code_ignore_a: assert property (
      s_other_code |=> $stable(bin_cnt) && $stable(disabled))
      else $error("invalid code had an effect");

   disable_gate_a: assert property (
      code_disable && wd_run_enable && !disabled && !int_rst
      |=> !disabled)
      else $error("disable code acted with enable set");

   hold_zero_a: assert property (
      disabled |=> bin_cnt == 2'h0)
      else $error("counter not held while disabled");

   nmi_wait_a: assert property (
      nmi_busy |=> !wd_pseudo_nmi_o)
      else $error("interrupt issued during handler");

   pulse_len_a: assert property (p_pulse_len)
      else $error("reset pulse length wrong");

   self_reset_a: assert property (
      $fell(pulse_active) |-> wd_run_enable && overflow_action_sel
      && (detect_time_sel == 2'h0) && (bin_cnt == 2'h0) && !disabled)
      else $error("watchdog reset did not restore state");

   early_ovf_a: assert property (
      ovf && !int_rst |-> clr_ticks == 2'h3)
      else $error("overflow before three ticks after clear");

   count_step_a: assert property (
      tick && run && !code_clear && !int_rst
      |=> bin_cnt == $past(bin_cnt) + 2'h1)
      else $error("counter did not step on tick");

   disable_take_a: assert property (
      code_disable && !wd_run_enable && !int_rst |=> disabled)
      else $error("disable code ignored with enable clear");

   nmi_issue_a: assert property (
      nmi_issue && !int_rst |=> wd_pseudo_nmi_o && nmi_busy)
      else $error("interrupt request not issued");

   sw_busy_wait_a: assert property (
      sw_nmi_busy_i |=> !wd_pseudo_nmi_o)
      else $error("interrupt issued during software handler");

   pin_drive_a: assert property (
      reset_pin_oe_o |-> !reset_pin_o)
      else $error("reset pin driven high");

   code_read_zero_a: assert property (
      wb_hit && !wb_we_i && reg_hit(wb_idx, `FST_CODE_IDX)
      |=> wb_ack_o && (wb_dat_o == 32'h00000000))
      else $error("code register read back");

endmodule

// File: test/fst_watchdog_test.sv
// Self-checking bench of the fail-safe timer top with short divider taps.
// Assumes fst_cfg.svh on the include path and one 125 MHz clock.
`timescale 1ns/1ns
`include "fst_cfg.svh"
module fst_watchdog_test;
   import fst_pkg::*;
   localparam int TAP = 7;
   localparam logic [9:0] CFG_A  = {`FST_CONFIG_IDX, 2'b00};
   localparam logic [9:0] CODE_A = {`FST_CODE_IDX, 2'b00};
   localparam logic [9:0] STAT_A = {`FST_STATUS_IDX, 2'b00};
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic        stop_i, idle_i, dv, nmi_return_from_nmi_instr_done_i, sw_nmi_busy_i;
   logic        wd_pseudo_nmi_o, chip_reset_o, reset_pin_o, reset_pin_oe_o;
   int          fail_count, checked, nmi_cnt, oe_cnt, crst_cnt, pin_bad;
   int          n0, o0;

   fst_watchdog #(.DIV_W(TAP + 2), .TAP_BASE(TAP)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .stop_i(stop_i), .idle_i(idle_i),
      .divider_stage_sel_i(dv), .nmi_return_from_nmi_instr_done_i(nmi_return_from_nmi_instr_done_i),
      .sw_nmi_busy_i(sw_nmi_busy_i), .wd_pseudo_nmi_o(wd_pseudo_nmi_o),
      .chip_reset_o(chip_reset_o), .reset_pin_o(reset_pin_o),
      .reset_pin_oe_o(reset_pin_oe_o));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      if (wd_pseudo_nmi_o === 1'b1) nmi_cnt++;
      if (reset_pin_oe_o === 1'b1) oe_cnt++;
      if (chip_reset_o === 1'b1) crst_cnt++;
      if (!rst_i && reset_pin_o !== 1'b0) pin_bad++;
   end

   function automatic int ovf(input int dts, input int d);
      return 4 * (1 << (TAP - 2 * dts + d)) + 8;
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Classic single cycle; waits for ack without assuming a latency
   task automatic bus(input logic we, input logic [9:0] adr,
                      input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      chk("bus ack", wb_ack_o, 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   task automatic junk;
      logic [7:0] d;
      do begin
         d = 8'($urandom);
      end while (d == `FST_CODE_CLEAR || d == `FST_CODE_DISABLE);
      bus(1'b1, CODE_A, d);
   endtask

   task automatic expect_reset(input int bound, input string name);
      int n, c0;
      o0 = oe_cnt;
      c0 = crst_cnt;
      n = 0;
      while (reset_pin_oe_o !== 1'b1 && n < bound) begin
         @(posedge clk_i);
         n++;
      end
      chk(name, reset_pin_oe_o, 1'b1);
      repeat (30) @(posedge clk_i);
      chk("pin low cycles", oe_cnt - o0, `FST_RST_CYC);
      chk("chip reset cycles", crst_cnt - c0, `FST_RST_CYC);
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, stop_i, idle_i} = 5'h00;
      {nmi_return_from_nmi_instr_done_i, sw_nmi_busy_i} = 2'h0;
      wb_adr_i = 10'h000;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h00000000;
      void'($urandom(32'h7891));
      dv = 1'($urandom);
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, CFG_A, 8'h00);
      chk("config read", q, 32'h00000000);
      bus(1'b0, 10'h3FC, 8'h00);
      chk("unmapped read", q, 32'h00000000);
      expect_reset(ovf(0, dv), "reset after boot");
      // Status after a pulse: out select and enable set, all else zero
      bus(1'b0, STAT_A, 8'h00);
      chk("status after pulse", q, 32'h00000024);
      bus(1'b1, CFG_A, 8'h0D);
      o0 = oe_cnt;
      repeat (30) begin
         junk();
         bus(1'b1, CODE_A, `FST_CODE_CLEAR);
         repeat ($urandom % 3) @(posedge clk_i);
      end
      chk("cleared no reset", oe_cnt - o0, 0);
      repeat (2) junk();
      expect_reset(ovf(2, dv), "junk is no clear");
      bus(1'b1, CFG_A, 8'h0F);
      bus(1'b1, CODE_A, `FST_CODE_CLEAR);
      o0 = oe_cnt;
      stop_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      stop_i <= 1'b0;
      bus(1'b1, CODE_A, `FST_CODE_CLEAR);
      idle_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      idle_i <= 1'b0;
      chk("held in low power", oe_cnt - o0, 0);
      expect_reset(ovf(3, dv), "resume after hold");
      bus(1'b1, CODE_A, `FST_CODE_DISABLE);
      bus(1'b1, CFG_A, 8'h03);
      expect_reset(ovf(1, dv), "late enable drop");
      bus(1'b1, CODE_A, `FST_CODE_CLEAR);
      bus(1'b1, CFG_A, 8'h05);
      bus(1'b1, CODE_A, `FST_CODE_DISABLE);
      // Disabled, reset action, detect code 10, counter held at zero
      bus(1'b0, STAT_A, 8'h00);
      chk("status disabled", q, 32'h00000070);
      o0 = oe_cnt;
      repeat (600) @(posedge clk_i);
      chk("disabled", oe_cnt - o0, 0);
      n0 = nmi_cnt;
      bus(1'b1, CFG_A, 8'h0E);
      repeat (ovf(3, dv)) @(posedge clk_i);
      chk("first nmi", nmi_cnt - n0, 1);
      repeat (100) @(posedge clk_i);
      chk("nmi waits return", nmi_cnt - n0, 1);
      bus(1'b1, CFG_A, 8'h0F);
      nmi_return_from_nmi_instr_done_i <= 1'b1;
      @(posedge clk_i);
      nmi_return_from_nmi_instr_done_i <= 1'b0;
      repeat (ovf(3, dv)) @(posedge clk_i);
      chk("second nmi", nmi_cnt - n0, 2);
      chk("select locked", oe_cnt - o0, 0);
      sw_nmi_busy_i <= 1'b1;
      nmi_return_from_nmi_instr_done_i <= 1'b1;
      @(posedge clk_i);
      nmi_return_from_nmi_instr_done_i <= 1'b0;
      repeat (100) @(posedge clk_i);
      chk("sw busy blocks", nmi_cnt - n0, 2);
      sw_nmi_busy_i <= 1'b0;
      repeat (ovf(3, dv)) @(posedge clk_i);
      chk("nmi after sw", nmi_cnt - n0, 3);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      n0 = nmi_cnt;
      expect_reset(ovf(0, dv), "reset restores");
      chk("no nmi after reset", nmi_cnt - n0, 0);
      chk("pin drive level", pin_bad, 0);
      tally_and_finish();
   end
endmodule
